// ===== hdl/throttle_pkg.sv
// package: register map, field layout, reset values and timing for the speed command block
package throttle_pkg;
    // register word offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FWD_CEIL = 8'h04;
    localparam logic [7:0] ADDR_FWD_FLOOR = 8'h08;
    localparam logic [7:0] ADDR_REV_CEIL = 8'h0c;
    localparam logic [7:0] ADDR_REV_FLOOR = 8'h10;
    localparam logic [7:0] ADDR_VLIMIT = 8'h14;
    localparam logic [7:0] ADDR_BAND = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;
    localparam logic [7:0] ADDR_ID = 8'h20;
    // ctrl field positions
    localparam int CTRL_TYPE_LSB = 0;
    localparam int CTRL_POT_EN = 4;
    localparam int CTRL_INTERLOCK_EN = 5;
    localparam int CTRL_NEUTRAL_IN_EN = 6;
    // speed words: mode 1 in bits 7:0, mode 2 in bits 15:8
    localparam int MODE2_LSB = 8;
    // vlimit: lower in 7:0, upper in 15:8 (full scale 255 = 5 V)
    localparam int UPPER_LSB = 8;
    // band: deadband in 7:0, full-output point in 15:8, percent
    localparam int FULL_LSB = 8;
    // reset values
    localparam logic [3:0] RST_TYPE = 4'h2;
    localparam logic [7:0] RST_CEIL = 8'h64;
    localparam logic [7:0] RST_FLOOR = 8'h00;
    localparam logic [7:0] RST_LOWER_V = 8'h00;
    localparam logic [7:0] RST_UPPER_V = 8'hff;
    localparam logic [7:0] RST_DEADBAND = 8'h0a;
    localparam logic [7:0] RST_FULL = 8'h64;
    // programmable ranges
    localparam logic [7:0] PCT_MAX = 8'h64;
    localparam logic [7:0] DEADBAND_MIN = 8'h05;
    localparam logic [7:0] DEADBAND_MAX = 8'h1e;
    localparam logic [7:0] FULL_MIN = 8'h28;
    localparam logic [7:0] UPPER_V_MIN = 8'h99;
    localparam logic [7:0] LOWER_V_MAX = 8'h66;
    localparam logic [3:0] TYPE_MAX = 4'h9;
    localparam logic [3:0] TYPE_FIRST_VOLT = 4'h5;
    // arbitrary identity value
    localparam logic [31:0] BLOCK_ID = 32'h0000_5a01;
    // interlock timeout
    localparam int CLK_HZ = 100_000_000;
    localparam int FAULT_TIME_S = 10;
    localparam longint FAULT_CYCLES = longint'(FAULT_TIME_S) * longint'(CLK_HZ);
endpackage : throttle_pkg

// ===== hdl/scale_if.sv
// interface: scaling request between the top and the interpolation unit
`timescale 1ns/1ns
`default_nettype none
interface scale_if;
    logic [7:0] pos;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] result;
    modport user (output pos, output lo, output hi, input result);
    modport unit (input pos, input lo, input hi, output result);
endinterface : scale_if
`default_nettype wire

// ===== hdl/speed_interp.sv
// interpolation unit: result = lo + (hi - lo) * pos / 255, registered
`timescale 1ns/1ns
`default_nettype none
module speed_interp
    import throttle_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    scale_if.unit s
);
    typedef struct packed
    {
        logic [7:0] result;
    } interp_state_t;
    interp_state_t state;
    interp_state_t next_state;
    logic [7:0] span;
    logic [15:0] prod;
    logic [8:0] sum;
    always_comb
    begin
        next_state = state;
        span = (s.hi > s.lo) ? 8'(s.hi - s.lo) : 8'h00;
        prod = span * s.pos;
        // pos 255 gives exactly hi
        sum = {1'b0, s.lo} + {1'b0, 8'(prod / 16'h00ff)};
        next_state.result = sum[8] ? 8'hff : sum[7:0];
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state <= '0;
        else
            state <= next_state;
    end
    assign s.result = state.result;
endmodule : speed_interp
`default_nettype wire

// ===== hdl/throttle_speed_command.sv
// top: throttle and speed-limit pot to speed request, with wishbone settings registers
// What this block does
// R1: mode switch at battery positive selects mode 2, otherwise mode 1.
// R2: separate ceiling and floor for forward and reverse per mode; active set used.
// R3: full-throttle limit interpolates linearly floor to ceiling by speed-limit pot.
// R4: pot at maximum and full throttle requests exactly the ceiling.
// R5: floor settings are clamped to never exceed the matching ceiling.
// R6: floors only take effect while the speed-limit pot is enabled.
// R7: type codes 0 to 4 decode resistive wigwag, inverted, single, inverted single, unipolar.
// R8: type codes 5 to 9 decode the same shapes for voltage throttles.
// R9: a setting enables detection of a dedicated neutral input.
// R10: voltage throttles take upper endpoint from a 3 to 5 V setting.
// R11: voltage throttles take lower endpoint from a 0 to 2 V setting.
// R12: resistive throttles ignore programmed voltage limits and use full pot span.
// R13: throttle inside the 5 to 30 percent deadband counts as neutral.
// R14: a 40 to 100 percent full point gives full output at 100 minus that percent of travel past the deadband.
// R15: interlock on: off-neutral throttle at power-up inhibits drive until neutral.
// R16: interlock held 10 seconds latches a wiring fault until power cycle.
// R17: a setting enables the speed-limit pot; off means pot is ignored.
// R18: pot disabled uses the active ceiling as the full-throttle limit.
`timescale 1ns/1ns
`default_nettype none
module throttle_speed_command
    import throttle_pkg::*;
#(
    parameter longint FAULT_CYCLES_P = FAULT_CYCLES
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] throttle_pos_i,
    input wire logic [7:0] limit_pot_i,
    input wire logic mode_switch_i,
    input wire logic neutral_in_i,
    output logic [7:0] speed_cmd_o,
    output logic reverse_o,
    output logic drive_inhibit_o,
    output logic wiring_fault_o,
    output logic neutral_o,
    output logic mode2_o
);
    typedef struct packed
    {
        logic ack;
        logic [31:0] rdata;
        logic [3:0] ttype;
        logic pot_en;
        logic interlock_en;
        logic neutral_in_en;
        logic [15:0] fwd_ceil;
        logic [15:0] fwd_floor;
        logic [15:0] rev_ceil;
        logic [15:0] rev_floor;
        logic [7:0] lower_v;
        logic [7:0] upper_v;
        logic [7:0] deadband;
        logic [7:0] full_pt;
        logic powered;
        logic interlock;
        logic fault;
        logic [39:0] timer;
        logic [7:0] cmd;
        logic reverse;
        logic neutral;
    } top_state_t;

    top_state_t state;
    top_state_t next_state;
    scale_if sif ();

    speed_interp u_interp
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .s(sif.unit)
    );

    // ==========================================================
    // combinational decode
    // ==========================================================
    logic mode2;
    logic is_volt;
    logic [2:0] shape;
    logic [7:0] lo_end;
    logic [7:0] hi_end;
    logic [7:0] norm;
    logic [8:0] dev2;
    logic [7:0] dev;
    logic dev_rev;
    logic [7:0] dead_cnt;
    logic [7:0] full_cnt;
    logic [7:0] drive_mag;
    logic [15:0] ramp;
    logic [7:0] ceil_sel;
    logic [7:0] floor_sel;
    logic [7:0] floor_clamped;
    logic [7:0] limit;
    logic [15:0] out_prod;
    logic in_neutral;
    logic wb_req;
    logic [31:0] wmask;
    logic [31:0] rd;
    logic [31:0] wv;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nv, input logic [31:0] m);
        merge16 = (old & ~m[15:0]) | (nv[15:0] & m[15:0]);
    endfunction : merge16

    function automatic logic [7:0] clip(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        clip = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clip

    always_comb
    begin
        next_state = state;
        mode2 = mode_switch_i; // [R1]
        is_volt = (state.ttype >= TYPE_FIRST_VOLT); // [R8]
        shape = is_volt ? 3'(state.ttype - TYPE_FIRST_VOLT) : state.ttype[2:0]; // [R7]
        // endpoints: programmed for voltage, full span for resistive
        lo_end = is_volt ? state.lower_v : 8'h00; // [R11] [R12]
        hi_end = is_volt ? state.upper_v : 8'hff; // [R10] [R12]
        if (throttle_pos_i <= lo_end)
            norm = 8'h00;
        else if (throttle_pos_i >= hi_end || hi_end <= lo_end)
            norm = 8'hff;
        else
            norm = 8'((16'(8'(throttle_pos_i - lo_end)) * 16'h00ff) / 16'(8'(hi_end - lo_end)));
        // inverted shapes mirror the travel
        if (shape == 3'd1 || shape == 3'd3)
            norm = 8'(8'hff - norm);
        // wigwag and unipolar centred; single-ended from low end
        dev_rev = 1'b0;
        dev = norm;
        dev2 = {norm, 1'b0};
        ramp = 16'h0000;
        case (shape)
            3'd0, 3'd1, 3'd4:
            begin
                if (norm >= 8'h80)
                    dev = (norm == 8'hff) ? 8'hff : 8'(dev2 - 9'h100);
                else
                begin
                    dev = 8'(9'h0ff - dev2);
                    // unipolar: direction comes from direction inputs outside this block
                    dev_rev = (shape != 3'd4);
                end
            end
            default:
            begin
                dev = norm;
            end
        endcase
        dead_cnt = 8'((16'(clip(state.deadband, DEADBAND_MIN, DEADBAND_MAX)) * 16'h00ff) / 16'h0064);
        full_cnt = 8'((16'(clip(state.full_pt, FULL_MIN, PCT_MAX)) * 16'h00ff) / 16'h0064);
        // higher full point means less travel to reach full output
        full_cnt = 8'(8'hff - full_cnt + dead_cnt); // [R14]
        if (full_cnt <= dead_cnt)
            full_cnt = 8'(dead_cnt + 8'h01);
        in_neutral = (dev <= dead_cnt) || (state.neutral_in_en && neutral_in_i); // [R13] [R9]
        if (in_neutral)
            drive_mag = 8'h00;
        else if (dev >= full_cnt)
            drive_mag = 8'hff; // [R14]
        else
        begin
            ramp = (16'(8'(dev - dead_cnt)) * 16'h00ff) / 16'(8'(full_cnt - dead_cnt));
            drive_mag = ramp[7:0];
        end
        // active ceiling and floor set
        if (dev_rev)
        begin
            ceil_sel = mode2 ? state.rev_ceil[15:8] : state.rev_ceil[7:0]; // [R2]
            floor_sel = mode2 ? state.rev_floor[15:8] : state.rev_floor[7:0];
        end
        else
        begin
            ceil_sel = mode2 ? state.fwd_ceil[15:8] : state.fwd_ceil[7:0]; // [R2]
            floor_sel = mode2 ? state.fwd_floor[15:8] : state.fwd_floor[7:0];
        end
        floor_clamped = (floor_sel > ceil_sel) ? ceil_sel : floor_sel; // [R5]
        sif.lo = floor_clamped; // [R3]
        sif.hi = ceil_sel;
        sif.pos = limit_pot_i; // [R4]
        // pot off: floor and pot have no effect
        limit = state.pot_en ? sif.result : ceil_sel; // [R6] [R17] [R18]
        out_prod = drive_mag * limit;
        // interlock: one cycle after reset release, sample throttle once
        next_state.powered = 1'b1;
        if (!state.powered)
            next_state.interlock = state.interlock_en && !in_neutral; // [R15]
        else if (in_neutral)
            next_state.interlock = 1'b0; // [R15]
        if (state.interlock && !state.fault)
        begin
            if (state.timer >= 40'(FAULT_CYCLES_P - 1))
                next_state.fault = 1'b1; // [R16]
            else
                next_state.timer = 40'(state.timer + 40'h00_0000_0001);
        end
        else if (!state.interlock)
            next_state.timer = '0;
        // no drive in the sampling cycle either, before the interlock has registered
        if (state.interlock || state.fault || in_neutral || !state.powered) // [R15] [R16]
            next_state.cmd = 8'h00;
        else
            next_state.cmd = 8'(out_prod / 16'h00ff);
        next_state.reverse = dev_rev;
        next_state.neutral = in_neutral;
        // ==========================================================
        // wishbone slave: one wait state, ack pulse
        // ==========================================================
        wb_req = wb_cyc_i && wb_stb_i && !state.ack;
        next_state.ack = wb_req;
        for (int i = 0; i < 4; i++)
            wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
        wv = wb_dat_i;
        case (wb_adr_i)
            ADDR_CTRL: rd = {25'h0, state.neutral_in_en, state.interlock_en, state.pot_en, state.ttype};
            ADDR_FWD_CEIL: rd = {16'h0, state.fwd_ceil};
            ADDR_FWD_FLOOR: rd = {16'h0, state.fwd_floor};
            ADDR_REV_CEIL: rd = {16'h0, state.rev_ceil};
            ADDR_REV_FLOOR: rd = {16'h0, state.rev_floor};
            ADDR_VLIMIT: rd = {16'h0, state.upper_v, state.lower_v};
            ADDR_BAND: rd = {16'h0, state.full_pt, state.deadband};
            ADDR_STATUS: rd = {24'h0, state.cmd[7:4] != 4'h0 ? 1'b1 : 1'b0, mode2, state.reverse,
                               state.neutral, 2'b00, state.fault, state.interlock};
            ADDR_ID: rd = BLOCK_ID;
            default: rd = 32'h0000_0000;
        endcase
        if (wb_req && !wb_we_i)
            next_state.rdata = rd;
        if (wb_req && wb_we_i)
        begin
            case (wb_adr_i)
                ADDR_CTRL:
                begin
                    // out-of-range type codes are rejected
                    if (wb_sel_i[0] && wv[CTRL_TYPE_LSB +: 4] <= TYPE_MAX)
                        next_state.ttype = wv[CTRL_TYPE_LSB +: 4];
                    if (wb_sel_i[0])
                    begin
                        next_state.pot_en = wv[CTRL_POT_EN];
                        next_state.interlock_en = wv[CTRL_INTERLOCK_EN];
                        next_state.neutral_in_en = wv[CTRL_NEUTRAL_IN_EN];
                    end
                end
                ADDR_FWD_CEIL: next_state.fwd_ceil = merge16(state.fwd_ceil, wv, wmask);
                ADDR_FWD_FLOOR: next_state.fwd_floor = merge16(state.fwd_floor, wv, wmask);
                ADDR_REV_CEIL: next_state.rev_ceil = merge16(state.rev_ceil, wv, wmask);
                ADDR_REV_FLOOR: next_state.rev_floor = merge16(state.rev_floor, wv, wmask);
                ADDR_VLIMIT: next_state.lower_v = wb_sel_i[0] ? clip(wv[7:0], 8'h00, LOWER_V_MAX) : state.lower_v;
                ADDR_BAND:
                begin
                    if (wb_sel_i[0])
                        next_state.deadband = clip(wv[7:0], DEADBAND_MIN, DEADBAND_MAX);
                    if (wb_sel_i[1])
                        next_state.full_pt = clip(wv[FULL_LSB +: 8], FULL_MIN, PCT_MAX);
                end
                default:
                begin
                end
            endcase
            if (wb_adr_i == ADDR_VLIMIT && wb_sel_i[1])
                next_state.upper_v = clip(wv[UPPER_LSB +: 8], UPPER_V_MIN, 8'hff);
        end
        // speeds above 100 percent are clipped per byte
        for (int m = 0; m < 2; m++)
        begin
            if (next_state.fwd_ceil[m*MODE2_LSB +: 8] > PCT_MAX)
                next_state.fwd_ceil[m*MODE2_LSB +: 8] = PCT_MAX;
            if (next_state.rev_ceil[m*MODE2_LSB +: 8] > PCT_MAX)
                next_state.rev_ceil[m*MODE2_LSB +: 8] = PCT_MAX;
            if (next_state.fwd_floor[m*MODE2_LSB +: 8] > PCT_MAX)
                next_state.fwd_floor[m*MODE2_LSB +: 8] = PCT_MAX;
            if (next_state.rev_floor[m*MODE2_LSB +: 8] > PCT_MAX)
                next_state.rev_floor[m*MODE2_LSB +: 8] = PCT_MAX;
        end
    end

    // ==========================================================
    // state register
    // ==========================================================
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= '0;
            state.ttype <= RST_TYPE;
            state.fwd_ceil <= {RST_CEIL, RST_CEIL};
            state.rev_ceil <= {RST_CEIL, RST_CEIL};
            state.fwd_floor <= {RST_FLOOR, RST_FLOOR};
            state.rev_floor <= {RST_FLOOR, RST_FLOOR};
            state.lower_v <= RST_LOWER_V;
            state.upper_v <= RST_UPPER_V;
            state.deadband <= RST_DEADBAND;
            state.full_pt <= RST_FULL;
            state.interlock_en <= 1'b1;
        end
        else
            state <= next_state;
    end

    assign wb_ack_o = state.ack;
    assign wb_dat_o = state.rdata;
    // speed request in percent 0..100 (capped by the active ceiling), interpolation adds one cycle of lag
    assign speed_cmd_o = state.cmd;
    assign reverse_o = state.reverse;
    assign drive_inhibit_o = state.interlock || state.fault;
    assign wiring_fault_o = state.fault;
    assign neutral_o = state.neutral;
    assign mode2_o = mode_switch_i;
endmodule : throttle_speed_command
`default_nettype wire

// ===== test/throttle_partner.sv
// partner model: throttle wiper, speed limit pot, mode switch and neutral input
`timescale 1ns/1ns
`default_nettype none
module throttle_partner
(
    input wire logic clk_i,
    output logic [7:0] throttle_pos_o,
    output logic [7:0] limit_pot_o,
    output logic mode_switch_o,
    output logic neutral_in_o
);
    logic [7:0] wiper = 8'h00;
    logic [7:0] pot = 8'h00;
    logic sw = 1'b0;
    logic nin = 1'b0;
    // non-blocking so a change never races the edge that samples it
    task automatic set(input logic [7:0] p, input logic [7:0] l, input logic m, input logic n);
        wiper <= p;
        pot <= l;
        sw <= m;
        nin <= n;
    endtask : set
    assign throttle_pos_o = wiper;
    assign limit_pot_o = pot;
    // floating switch reads low, battery positive reads high
    assign mode_switch_o = sw;
    assign neutral_in_o = nin;
endmodule : throttle_partner
`default_nettype wire

// ===== test/throttle_speed_command_sva.sv
// checker: port-level assertions for the speed command block
`timescale 1ns/1ns
`default_nettype none
module throttle_speed_command_sva
    import throttle_pkg::*;
#(
    parameter longint FAULT_CYCLES_P = FAULT_CYCLES
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic mode_switch_i,
    input wire logic mode2_o,
    input wire logic [7:0] speed_cmd_o,
    input wire logic drive_inhibit_o,
    input wire logic wiring_fault_o,
    input wire logic neutral_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // interlock age counter
    longint held;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !drive_inhibit_o || wiring_fault_o)
            held <= 0;
        else
            held <= held + 1;
    end
    // ==========================================
    // properties
    property p_mode2; mode2_o == mode_switch_i; endproperty
    a_mode2: assert property (p_mode2) else $error("mode output off switch");
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack one cycle after request");
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_cmd_cap; speed_cmd_o <= PCT_MAX; endproperty
    a_cmd_cap: assert property (p_cmd_cap) else $error("speed above full scale");
    property p_fault_hold; wiring_fault_o |=> wiring_fault_o; endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault released");
    property p_fault_inhibit; wiring_fault_o |-> drive_inhibit_o; endproperty
    a_fault_inhibit: assert property (p_fault_inhibit) else $error("fault without inhibit");
    property p_fault_cause; $rose(wiring_fault_o) |-> $past(drive_inhibit_o); endproperty
    a_fault_cause: assert property (p_fault_cause) else $error("fault without interlock");
    property p_fault_bound; held <= FAULT_CYCLES_P + 4; endproperty
    a_fault_bound: assert property (p_fault_bound) else $error("fault late");
    property p_inhibit_quiet; drive_inhibit_o |-> speed_cmd_o == 8'h00; endproperty
    a_inhibit_quiet: assert property (p_inhibit_quiet) else $error("drive while inhibited");
    property p_neutral_quiet; neutral_o |-> speed_cmd_o == 8'h00; endproperty
    a_neutral_quiet: assert property (p_neutral_quiet) else $error("drive in neutral");
endmodule : throttle_speed_command_sva
bind throttle_speed_command throttle_speed_command_sva #(.FAULT_CYCLES_P(FAULT_CYCLES_P)) sva_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .mode_switch_i(mode_switch_i), .mode2_o(mode2_o), .speed_cmd_o(speed_cmd_o),
    .drive_inhibit_o(drive_inhibit_o), .wiring_fault_o(wiring_fault_o), .neutral_o(neutral_o));
`default_nettype wire

// ===== test/testbench.sv
// testbench: speed command block against a model of the speed rules
`timescale 1ns/1ns
`default_nettype none
module testbench
    import throttle_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    wire logic [7:0] pos;
    wire logic [7:0] pot;
    wire logic mode_sw;
    wire logic nin;
    logic [7:0] cmd;
    logic rev, inhibit, fault, neutral, mode2;
    int err_count = 0;
    int check_count = 0;
    int fc[2], ff[2], rc[2], rf[2];
    logic [7:0] fwd_pos[5] = '{8'hff, 8'h00, 8'hff, 8'h00, 8'hff};
    logic [7:0] neu_pos[5] = '{8'h80, 8'h80, 8'h00, 8'hff, 8'h80};
    throttle_partner throttle_partner_inst (.clk_i(clk), .throttle_pos_o(pos), .limit_pot_o(pot),
        .mode_switch_o(mode_sw), .neutral_in_o(nin));
    // short fault timer keeps the run brief
    throttle_speed_command #(.FAULT_CYCLES_P(50)) throttle_speed_command_inst (.clk_i(clk), .rst_i(rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .throttle_pos_i(pos), .limit_pot_i(pot), .mode_switch_i(mode_sw),
        .neutral_in_i(nin), .speed_cmd_o(cmd), .reverse_o(rev), .drive_inhibit_o(inhibit),
        .wiring_fault_o(fault), .neutral_o(neutral), .mode2_o(mode2));
    initial
    begin
        forever #5 clk = ~clk;
    end
    // ==========================================
    // model and helpers
    function automatic int limit(int c, int f, int en, int p);
        if (en == 0)
            return c;
        f = (f > c) ? c : f;
        return f + (c - f) * p / 255;
    endfunction : limit
    task automatic complete_run();
        if (err_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // only the watchdog ends a wait for ack
        do
            @(posedge clk);
        while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        chk(q, e);
    endtask : rd
    task automatic drive(input logic [7:0] p, input logic [7:0] l, input logic m, input logic n);
        throttle_partner_inst.set(p, l, m, n);
        repeat (6) @(posedge clk);
    endtask : drive
    task automatic do_reset(input logic [7:0] p);
        throttle_partner_inst.set(p, 8'h00, 1'b0, 1'b0);
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : do_reset
    task automatic out(input int c, input logic r);
        chk({23'h0, r, cmd}, {23'h0, r, 8'(c)});
        chk({31'h0, rev}, {31'h0, r});
    endtask : out
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run();
    end
    // ==========================================
    // scenarios
    initial
    begin
        int pv;
        void'($urandom(6492));
        do_reset(8'h00);
        rd(ADDR_CTRL, 32'h0000_0022);
        rd(ADDR_FWD_CEIL, 32'h0000_6464);
        rd(ADDR_REV_FLOOR, 32'h0000_0000);
        rd(ADDR_VLIMIT, 32'h0000_ff00);
        rd(ADDR_BAND, 32'h0000_640a);
        rd(ADDR_ID, BLOCK_ID);
        rd(8'h24, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_002c);
        rd(ADDR_CTRL, 32'h0000_0022);
        wr(ADDR_REV_CEIL, 32'h0000_c8c8);
        rd(ADDR_REV_CEIL, 32'h0000_6464);
        wr(ADDR_BAND, 32'h0000_1402);
        rd(ADDR_BAND, 32'h0000_2805);
        wr(ADDR_VLIMIT, 32'h0000_10ff);
        rd(ADDR_VLIMIT, 32'h0000_9966);
        wr(ADDR_BAND, 32'h0000_640a);
        wr(ADDR_VLIMIT, 32'h0000_ff00);
        // mode 1 forward floor above its ceiling on purpose
        for (int m = 0; m < 2; m++)
        begin
            fc[m] = $urandom_range(100);
            ff[m] = $urandom_range(100);
            rc[m] = $urandom_range(100);
            rf[m] = $urandom_range(100);
        end
        fc[0] = 40;
        ff[0] = 80;
        wr(ADDR_FWD_CEIL, 32'((fc[1] << 8) | fc[0]));
        wr(ADDR_FWD_FLOOR, 32'((ff[1] << 8) | ff[0]));
        wr(ADDR_REV_CEIL, 32'((rc[1] << 8) | rc[0]));
        wr(ADDR_REV_FLOOR, 32'((rf[1] << 8) | rf[0]));
        for (int m = 0; m < 2; m++)
            for (int e = 0; e < 2; e++)
                for (int k = 0; k < 3; k++)
                begin
                    pv = (k == 0) ? 0 : (k == 1) ? 255 : $urandom_range(255);
                    wr(ADDR_CTRL, 32'(32'h20 | (e << 4) | 2));
                    drive(8'hff, 8'(pv), m[0], 1'b0);
                    out(limit(fc[m], ff[m], e, pv), 1'b0);
                    chk({31'h0, mode2}, 32'(m));
                    wr(ADDR_CTRL, 32'(32'h20 | (e << 4)));
                    drive(8'h00, 8'(pv), m[0], 1'b0);
                    out(limit(rc[m], rf[m], e, pv), 1'b1);
                end
        // every throttle shape, pot disabled
        for (int t = 0; t < 10; t++)
        begin
            wr(ADDR_CTRL, 32'(32'h20 | t));
            drive(fwd_pos[t % 5], 8'h00, 1'b0, 1'b0);
            out(fc[0], 1'b0);
            drive(neu_pos[t % 5], 8'h00, 1'b0, 1'b0);
            chk({31'h0, neutral}, 32'h1);
            // wigwag reverses below centre; unipolar stays forward
            if (t % 5 < 2 || t % 5 == 4)
            begin
                drive(~fwd_pos[t % 5], 8'h00, 1'b0, 1'b0);
                out((t % 5 < 2) ? rc[0] : fc[0], t % 5 < 2);
            end
        end
        // programmed voltage span applies to voltage types only
        wr(ADDR_VLIMIT, 32'h0000_b050);
        wr(ADDR_CTRL, 32'h0000_0027);
        drive(8'h50, 8'h00, 1'b0, 1'b0);
        chk({31'h0, neutral}, 32'h1);
        drive(8'hb0, 8'h00, 1'b0, 1'b0);
        out(fc[0], 1'b0);
        wr(ADDR_CTRL, 32'h0000_0022);
        drive(8'h50, 8'h00, 1'b0, 1'b0);
        chk({31'h0, neutral}, 32'h0);
        wr(ADDR_VLIMIT, 32'h0000_ff00);
        // deadband width and full-output point
        wr(ADDR_BAND, 32'h0000_641e);
        drive(8'h3c, 8'h00, 1'b0, 1'b0);
        chk({31'h0, neutral}, 32'h1);
        wr(ADDR_BAND, 32'h0000_6405);
        drive(8'h3c, 8'h00, 1'b0, 1'b0);
        chk({31'h0, neutral}, 32'h0);
        drive(8'h80, 8'h00, 1'b0, 1'b0);
        out(fc[0], 1'b0);
        wr(ADDR_BAND, 32'h0000_2805);
        drive(8'h80, 8'h00, 1'b0, 1'b0);
        chk(32'(cmd < 8'd40), 32'h1);
        // dedicated neutral input
        wr(ADDR_CTRL, 32'h0000_0062);
        drive(8'hff, 8'h00, 1'b0, 1'b1);
        chk({31'h0, neutral}, 32'h1);
        wr(ADDR_CTRL, 32'h0000_0022);
        drive(8'hff, 8'h00, 1'b0, 1'b1);
        chk({31'h0, neutral}, 32'h0);
        // power-up with throttle applied, released in time
        do_reset(8'hff);
        repeat (3) @(posedge clk);
        chk({30'h0, inhibit, fault}, 32'h2);
        out(0, 1'b0);
        drive(8'h00, 8'h00, 1'b0, 1'b0);
        chk({31'h0, inhibit}, 32'h0);
        drive(8'hff, 8'h00, 1'b0, 1'b0);
        out(100, 1'b0);
        // held past the fault time
        do_reset(8'hff);
        repeat (20) @(posedge clk);
        chk({31'h0, fault}, 32'h0);
        repeat (50) @(posedge clk);
        chk({31'h0, fault}, 32'h1);
        drive(8'h00, 8'h00, 1'b0, 1'b0);
        chk({30'h0, inhibit, fault}, 32'h3);
        do_reset(8'h00);
        chk({30'h0, inhibit, fault}, 32'h0);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
